// ==== pkg/txq_cfg.svh ====
// Purpose: Offsets, field positions, reset values and counts of the transmit queue block
// Assumes: Word registers on a plain strobe port, 8-bit data
// Notes:   Included by the package and the design files
`ifndef TXQ_CFG_SVH
`define TXQ_CFG_SVH

// Register offsets
`define TXQ_OFS_MMU_CMD     4'h0
`define TXQ_OFS_ALLOC_RES   4'h1
`define TXQ_OFS_PKT_NUM     4'h2
`define TXQ_OFS_FIFO_PORTS  4'h3
`define TXQ_OFS_PTR         4'h4
`define TXQ_OFS_DATA        4'h5
`define TXQ_OFS_TX_CTRL     4'h6
`define TXQ_OFS_INT_STAT    4'h7
`define TXQ_OFS_INT_MASK    4'h8
`define TXQ_OFS_LINK_STAT   4'h9
`define TXQ_OFS_CTRL        4'hA

// Command codes in MMU command bits 7:5
`define TXQ_CMD_ALLOC       3'h1
`define TXQ_CMD_RELEASE     3'h5
`define TXQ_CMD_ENQUEUE     3'h6

// Interrupt status and mask bit positions
`define TXQ_INT_TX          0
`define TXQ_INT_ALLOC       1
`define TXQ_INT_DRAINED     2

// Control bits
`define TXQ_TCR_TXEN_BIT    0
`define TXQ_CTRL_AUTOREL    0
`define TXQ_CTRL_HALFDUP    1

// Allocation result fail bit
`define TXQ_ALLOC_FAIL_BIT  7

// Reset values
`define TXQ_RST_CTRL        8'h01
`define TXQ_RST_MASK        8'h00
`define TXQ_RST_TCR         8'h00

// Packet numbers, pages, fifo depth
`define TXQ_PN_W            3
`define TXQ_NPKT            8
`define TXQ_PAGE_BYTES      256
`define TXQ_NPAGES          16
`define TXQ_FIFO_DEPTH      8

`endif

// ==== pkg/txq_pkg.sv ====
// Purpose: Types of the transmit queue block
// Assumes: txq_cfg.svh holds the numbers
// Notes:   None
`include "txq_cfg.svh"
package txq_pkg;
  typedef logic [`TXQ_PN_W-1:0] txq_pn_t;
  typedef logic [7:0]           txq_byte_t;
  typedef enum logic [1:0] {TXQ_IDLE, TXQ_SEND, TXQ_DONE} txq_state_t;
endpackage

// ==== src/txq_mmu.sv ====
// Purpose: Packet number and page allocator
// Assumes: One allocate and one release per cycle at most
// Notes:   Pages counted only, not placed
`timescale 1ns/100ps
`default_nettype none
`include "txq_cfg.svh"
module txq_mmu (
  // Clock and reset
  input  wire logic            mclk,
  input  wire logic            rst,
  // Allocate
  input  wire logic            alloc_req,
  input  wire logic [7:0]      alloc_pages,
  output logic                 alloc_ok,
  output logic                 alloc_fail,
  output txq_pkg::txq_pn_t     alloc_pn,
  // Release
  input  wire logic            rel_req,
  input  wire txq_pkg::txq_pn_t rel_pn,
  // Status
  output logic [7:0]           free_pages
);
  import txq_pkg::*;

  logic [`TXQ_NPKT-1:0] used_r;
  logic [7:0]           pages_r [`TXQ_NPKT];
  logic [7:0]           free_r;
  logic                 found;
  txq_pn_t              first_free;
  logic                 fits;
  logic [7:0]           rel_cnt;

  always_comb begin
    found      = 1'b0;
    first_free = '0;
    for (int i = `TXQ_NPKT-1; i >= 0; i--) begin
      if (!used_r[i]) begin
        found      = 1'b1;
        first_free = txq_pn_t'(i);
      end
    end
  end

  assign fits       = found && (alloc_pages <= free_r);
  assign rel_cnt    = (rel_req && used_r[rel_pn]) ? pages_r[rel_pn] : 8'h00;
  assign alloc_ok   = alloc_req && fits;
  assign alloc_fail = alloc_req && !fits;
  assign alloc_pn   = first_free;
  assign free_pages = free_r;

  always_ff @(posedge mclk) begin
    if (rst) begin
      used_r <= '0;
      free_r <= 8'(`TXQ_NPAGES);
    end else begin
      free_r <= free_r + rel_cnt - (alloc_ok ? alloc_pages : 8'h00);
      if (rel_req)
        used_r[rel_pn] <= 1'b0;
      if (alloc_ok) begin
        used_r[first_free]  <= 1'b1;
        pages_r[first_free] <= alloc_pages;
      end
    end
  end
endmodule
`default_nettype wire

// ==== src/txq_fifo.sv ====
// Purpose: Packet number FIFO in flip-flops
// Assumes: Push to full and pop from empty are ignored
// Notes:   Depth fixed
`timescale 1ns/100ps
`default_nettype none
`include "txq_cfg.svh"
module txq_fifo (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             rst,
  // Push side
  input  wire logic             push,
  input  wire txq_pkg::txq_pn_t push_pn,
  // Pop side
  input  wire logic             pop,
  output txq_pkg::txq_pn_t      head_pn,
  // Status
  output logic                  empty,
  output logic                  full
);
  import txq_pkg::*;

  txq_pn_t    mem_r [`TXQ_FIFO_DEPTH];
  logic [2:0] wp_r;
  logic [2:0] rp_r;
  logic [3:0] cnt_r;
  logic       do_push;
  logic       do_pop;

  assign empty   = (cnt_r == 4'h0);
  assign full    = (cnt_r == 4'(`TXQ_FIFO_DEPTH));
  assign do_push = push && !full;
  assign do_pop  = pop && !empty;
  assign head_pn = mem_r[rp_r];

  always_ff @(posedge mclk) begin
    if (rst) begin
      wp_r  <= 3'h0;
      rp_r  <= 3'h0;
      cnt_r <= 4'h0;
    end else begin
      if (do_push) begin
        mem_r[wp_r] <= push_pn;
        wp_r        <= wp_r + 3'h1;
      end
      if (do_pop)
        rp_r <= rp_r + 3'h1;
      cnt_r <= cnt_r + {3'h0, do_push} - {3'h0, do_pop};
    end
  end
endmodule
`default_nettype wire

// ==== src/txq_top.sv ====
// Purpose: Transmit queue with automatic release, register port and interrupt
// Assumes: MAC gives one done pulse with ok or fail per started packet
// Notes:   Packet data storage is outside; pointer and data writes are forwarded
// Function
// - Allocate command asks the memory manager for command bits 4:0 plus one pages.
// - Successful allocation sets the allocation-done flag.
// - Allocation interrupt only reaches the output when its mask bit is set.
// - Allocated packet number is shown in the allocation result register.
// - Enqueue pushes the packet number register into the transmit FIFO.
// - Packet goes to MAC only with transmit enable, and deferral in half duplex.
// - Automatic release frees pages of each packet that completes without failure, unless a release command is written in the same cycle.
// - Queue drained interrupt rises when the enqueued sequence has finished.
// - Failure sets transmit flag, clears transmit enable, stops sequence.
// - FIFO ports register shows the completion FIFO head, or the last failed packet number while that FIFO is empty.
// - Transmit flag stays set while the completion FIFO holds an entry.
// - Drained flag stays set while the transmit FIFO is empty and the sequencer is idle.
// - With automatic release, good packets skip the completion FIFO.
`timescale 1ns/100ps
`default_nettype none
`include "txq_cfg.svh"
module txq_top (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             rst,
  // Register port
  input  wire logic [3:0]       reg_addr,
  input  wire logic [7:0]       reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output logic [7:0]            reg_rdata,
  // Packet buffer access
  output logic                  buf_wr,
  output logic [7:0]            buf_ptr,
  output logic [7:0]            buf_wdata,
  // MAC side
  input  wire logic             defer_ok,
  input  wire logic [7:0]       link_layer_status,
  output logic                  mac_start,
  output txq_pkg::txq_pn_t      mac_pn,
  input  wire logic             mac_done,
  input  wire logic             mac_fail,
  // Interrupt
  output logic                  irq
);
  import txq_pkg::*;

  txq_state_t state_r;
  txq_state_t state_nxt;
  txq_byte_t  transmit_control_reg_r;
  txq_byte_t  ctrl_r;
  txq_byte_t  mask_r;
  txq_byte_t  alloc_res_r;
  txq_pn_t    pkt_num_r;
  txq_pn_t    fail_pn_r;
  txq_pn_t    cur_pn_r;
  logic [7:0] ptr_r;
  logic       alloc_done_r;
  logic [7:0] bufp_r;
  logic [7:0] rdata_r;
  logic [7:0] bufd_r;
  logic       bufw_r;
  logic       defer_s1_r;
  logic       defer_s2_r;

  // Decode
  wire        wr_cmd     = reg_wr && (reg_addr == `TXQ_OFS_MMU_CMD);
  wire [2:0]  cmd        = reg_wdata[7:5];
  wire        cmd_alloc  = wr_cmd && (cmd == `TXQ_CMD_ALLOC);
  wire        cmd_rel    = wr_cmd && (cmd == `TXQ_CMD_RELEASE);
  wire        cmd_enq    = wr_cmd && (cmd == `TXQ_CMD_ENQUEUE);
  wire        wr_pnr     = reg_wr && (reg_addr == `TXQ_OFS_PKT_NUM);
  wire        wr_ptr     = reg_wr && (reg_addr == `TXQ_OFS_PTR);
  wire        wr_data    = reg_wr && (reg_addr == `TXQ_OFS_DATA);
  wire        wr_tcr     = reg_wr && (reg_addr == `TXQ_OFS_TX_CTRL);
  wire        wr_stat    = reg_wr && (reg_addr == `TXQ_OFS_INT_STAT);
  wire        wr_mask    = reg_wr && (reg_addr == `TXQ_OFS_INT_MASK);
  wire        wr_ctrl    = reg_wr && (reg_addr == `TXQ_OFS_CTRL);
  wire        auto_rel   = ctrl_r[`TXQ_CTRL_AUTOREL];
  wire        half_dup   = ctrl_r[`TXQ_CTRL_HALFDUP];
  wire        tx_en      = transmit_control_reg_r[`TXQ_TCR_TXEN_BIT];

  // Command bits 4:0 hold the page count minus one
  wire [7:0]  req_pages  = reg_wdata[4:0] + 8'h01;

  // Memory manager
  logic       alloc_ok;
  logic       alloc_fail;
  txq_pn_t    alloc_pn;
  logic [7:0] free_pages;
  logic       mmu_rel;
  txq_pn_t    mmu_rel_pn;

  // MAC completion decode
  wire        tx_done_ok   = (state_r == TXQ_SEND) && mac_done && !mac_fail;
  wire        tx_done_bad  = (state_r == TXQ_SEND) && mac_done && mac_fail;

  wire        auto_free    = tx_done_ok && auto_rel;
  wire        to_compl     = (tx_done_ok && !auto_rel) || tx_done_bad;

  // Release by software has priority; auto free is a one-cycle event
  assign mmu_rel    = cmd_rel || auto_free;
  assign mmu_rel_pn = cmd_rel ? pkt_num_r : cur_pn_r;

  txq_mmu u_mmu (
    .mclk        (mclk),
    .rst         (rst),
    .alloc_req   (cmd_alloc),
    .alloc_pages (req_pages),
    .alloc_ok    (alloc_ok),
    .alloc_fail  (alloc_fail),
    .alloc_pn    (alloc_pn),
    .rel_req     (mmu_rel),
    .rel_pn      (mmu_rel_pn),
    .free_pages  (free_pages)
  );

  // Transmit queue
  logic       txf_empty;
  logic       txf_full;
  txq_pn_t    txf_head;
  wire        start_ok   = (state_r == TXQ_IDLE) && !txf_empty && tx_en
                           && (!half_dup || defer_s2_r);

  txq_fifo u_txf (
    .mclk    (mclk),
    .rst     (rst),
    .push    (cmd_enq),
    .push_pn (pkt_num_r),
    .pop     (start_ok),
    .head_pn (txf_head),
    .empty   (txf_empty),
    .full    (txf_full)
  );

  // Completion queue, acknowledged by writing one to the transmit status bit
  logic       cf_empty;
  logic       cf_full;
  txq_pn_t    cf_head;
  wire        cf_ack = wr_stat && reg_wdata[`TXQ_INT_TX];

  txq_fifo u_cf (
    .mclk    (mclk),
    .rst     (rst),
    .push    (to_compl),
    .push_pn (cur_pn_r),
    .pop     (cf_ack),
    .head_pn (cf_head),
    .empty   (cf_empty),
    .full    (cf_full)
  );

  wire        tx_flag      = !cf_empty;
  wire        drained_flag = txf_empty && (state_r == TXQ_IDLE);
  wire [7:0]  int_stat     = {5'h00, drained_flag, alloc_done_r, tx_flag};
  assign irq = |(int_stat & mask_r);

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      TXQ_IDLE: if (start_ok) state_nxt = TXQ_SEND;
      TXQ_SEND: if (mac_done) state_nxt = TXQ_DONE;
      TXQ_DONE: state_nxt = TXQ_IDLE;
      default:  state_nxt = TXQ_IDLE;
    endcase
  end

  // Read mux; unmapped offsets read zero
  wire [7:0] rd_mux =
    (reg_addr == `TXQ_OFS_ALLOC_RES)  ? alloc_res_r :
    (reg_addr == `TXQ_OFS_PKT_NUM)    ? {5'h00, pkt_num_r} :
    (reg_addr == `TXQ_OFS_FIFO_PORTS) ? {txf_empty, 4'h0, (cf_empty ? fail_pn_r : cf_head)} :
    (reg_addr == `TXQ_OFS_PTR)        ? ptr_r :
    (reg_addr == `TXQ_OFS_TX_CTRL)    ? transmit_control_reg_r :
    (reg_addr == `TXQ_OFS_INT_STAT)   ? int_stat :
    (reg_addr == `TXQ_OFS_INT_MASK)   ? mask_r :
    (reg_addr == `TXQ_OFS_LINK_STAT)  ? link_layer_status :
    (reg_addr == `TXQ_OFS_CTRL)       ? ctrl_r : 8'h00;

  // Two flip-flops: deferral comes from outside this clock domain
  always_ff @(posedge mclk) begin
    if (rst) begin
      defer_s1_r <= 1'b0;
      defer_s2_r <= 1'b0;
    end else begin
      defer_s1_r <= defer_ok;
      defer_s2_r <= defer_s1_r;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_r  <= TXQ_IDLE;
      cur_pn_r <= '0;
    end else begin
      state_r <= state_nxt;
      if (start_ok)
        cur_pn_r <= txf_head;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      transmit_control_reg_r <= `TXQ_RST_TCR;
    end else if (tx_done_bad) begin
      transmit_control_reg_r[`TXQ_TCR_TXEN_BIT] <= 1'b0;
    end else if (wr_tcr) begin
      transmit_control_reg_r <= reg_wdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst)
      alloc_done_r <= 1'b0;
    else if (alloc_ok)
      alloc_done_r <= 1'b1;
    else if (wr_stat && reg_wdata[`TXQ_INT_ALLOC])
      alloc_done_r <= 1'b0;
  end

  // result register
  // A refused request shows the fail bit, so a poller never takes a stale number
  always_ff @(posedge mclk) begin
    if (rst)
      alloc_res_r <= 8'h80;
    else if (alloc_ok)
      alloc_res_r <= {5'h00, alloc_pn};
    else if (alloc_fail)
      alloc_res_r <= 8'h80;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl_r <= `TXQ_RST_CTRL;
      mask_r <= `TXQ_RST_MASK;
    end else begin
      if (wr_ctrl)
        ctrl_r <= reg_wdata;
      if (wr_mask)
        mask_r <= reg_wdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst)
      pkt_num_r <= '0;
    else if (wr_pnr)
      pkt_num_r <= reg_wdata[`TXQ_PN_W-1:0];
  end

  // pointer then data
  // Each data write steps the pointer, so a block move needs one pointer write
  always_ff @(posedge mclk) begin
    if (rst)
      ptr_r <= 8'h00;
    else if (wr_ptr)
      ptr_r <= reg_wdata;
    else if (wr_data)
      ptr_r <= ptr_r + 8'h01;
  end

  always_ff @(posedge mclk) begin
    if (rst)
      fail_pn_r <= '0;
    else if (tx_done_bad)
      fail_pn_r <= cur_pn_r;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      rdata_r <= 8'h00;
      bufw_r  <= 1'b0;
      bufd_r  <= 8'h00;
      bufp_r  <= 8'h00;
    end else begin
      rdata_r <= reg_rd ? rd_mux : 8'h00;
      bufw_r  <= wr_data;
      bufd_r  <= reg_wdata;
      bufp_r  <= ptr_r;
    end
  end

  assign reg_rdata = rdata_r;
  assign buf_wr    = bufw_r;
  assign buf_wdata = bufd_r;
  assign buf_ptr   = bufp_r;
  assign mac_start = (state_r == TXQ_SEND);
  assign mac_pn    = cur_pn_r;
endmodule
`default_nettype wire

// ==== sim/txq_chk_sva.sv ====
// Purpose: Port assertions of the transmit queue
// Assumes: Enable and mask mirrored from register writes
// Notes:   Bound into txq_top
`timescale 1ns/100ps
`default_nettype none
`include "txq_cfg.svh"
module txq_chk (
  // Clock and register port
  input wire logic             mclk,
  input wire logic             rst,
  input wire logic [3:0]       reg_addr,
  input wire logic [7:0]       reg_wdata,
  input wire logic             reg_wr,
  // Buffer, MAC, interrupt
  input wire logic             buf_wr,
  input wire logic [7:0]       buf_ptr,
  input wire logic [7:0]       buf_wdata,
  input wire logic             mac_start,
  input wire txq_pkg::txq_pn_t mac_pn,
  input wire logic             mac_done,
  input wire logic             mac_fail,
  input wire logic             irq
);
  import txq_pkg::*;
  logic            ten_r;
  logic [7:0]      mask_r;
  wire logic       wr_dat = reg_wr && reg_addr == `TXQ_OFS_DATA;
  wire logic       wr_ptr = reg_wr && reg_addr == `TXQ_OFS_PTR;
  wire logic       wr_ten = reg_wr && reg_addr == `TXQ_OFS_TX_CTRL;
  wire logic       wr_msk = reg_wr && reg_addr == `TXQ_OFS_INT_MASK;
  wire logic       fail_ev = mac_start && mac_done && mac_fail;
  // Failure wins over a same-cycle enable write
  wire logic       ten_nxt = !fail_ev && (wr_ten ? reg_wdata[`TXQ_TCR_TXEN_BIT] : ten_r);
  wire logic [7:0] mask_nxt = wr_msk ? reg_wdata : mask_r;
  always_ff @(posedge mclk) begin
    ten_r  <= !rst && ten_nxt;
    mask_r <= rst ? `TXQ_RST_MASK : mask_nxt;
  end
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  sequence s_ptr_dat;
    wr_ptr ##2 wr_dat;
  endsequence
  chk_start_enable: assert property (
    $rose(mac_start) |-> $past(ten_r)) else $error("start without enable");
  chk_start_holds: assert property (
    mac_start && !mac_done |=> mac_start) else $error("send dropped early");
  chk_done_ends: assert property (
    mac_start && mac_done |=> !mac_start) else $error("send not ended");
  chk_pn_stable: assert property (
    mac_start && $past(mac_start) |-> $stable(mac_pn)) else $error("number moved");
  chk_fail_halt: assert property (
    fail_ev ##1 !wr_ten [*3] |=> !mac_start) else $error("no halt on failure");
  chk_buf_copy: assert property (
    wr_dat |=> buf_wr && buf_wdata == $past(reg_wdata)) else $error("data not passed");
  chk_ptr_load: assert property (
    s_ptr_dat |=> buf_ptr == $past(reg_wdata, 3)) else $error("pointer not loaded");
  chk_ptr_step: assert property (
    buf_wr && $past(buf_wr, 2) |-> buf_ptr == $past(buf_ptr, 2) + 8'h01)
    else $error("pointer not stepped");
  chk_irq_masked: assert property (
    mask_r == 8'h00 |-> !irq) else $error("irq while masked");
endmodule
bind txq_top txq_chk txq_chk_inst (.mclk(mclk), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .buf_wr(buf_wr), .buf_ptr(buf_ptr),
  .buf_wdata(buf_wdata), .mac_start(mac_start), .mac_pn(mac_pn), .mac_done(mac_done),
  .mac_fail(mac_fail), .irq(irq));
`default_nettype wire

// ==== sim/txq_mac_model.sv ====
// Purpose: MAC stand-in answering each send
// Assumes: One send at a time
// Notes:   Bench sets delay and failure
`timescale 1ns/100ps
`default_nettype none
module txq_mac_model (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             rst,
  // Send link
  input  wire logic             mac_start,
  input  wire txq_pkg::txq_pn_t mac_pn,
  output logic                  mac_done,
  output logic                  mac_fail,
  // Bench control
  input  wire logic [3:0]       delay,
  input  wire logic             fail_next,
  output logic [7:0]            n_sent,
  output txq_pkg::txq_pn_t      last_pn
);
  import txq_pkg::*;
  logic [3:0] cnt_r;
  wire logic  fin = !rst && mac_start && !mac_done && cnt_r == delay;
  always_ff @(posedge mclk) begin
    cnt_r    <= (mac_start && !mac_done) ? cnt_r + 4'h1 : 4'h0;
    mac_done <= fin;
    // Qualifier flips outside done so a stale value is never trusted
    mac_fail <= fin ? fail_next : !fail_next;
    n_sent   <= rst ? 8'h00 : n_sent + {7'h00, fin};
    last_pn  <= fin ? mac_pn : last_pn;
  end
endmodule
`default_nettype wire

// ==== sim/txq_top_test.sv ====
// Purpose: Self-checking bench of the transmit queue
// Assumes: MAC model answers every start
// Notes:   Waits are bounded; a spent wait for sends ends the run
`timescale 1ns/100ps
`default_nettype none
`include "txq_cfg.svh"
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin num_errors++; \
  $display("[ERR] %s exp %0h got %0h", nm, ex, got); end end
module txq_top_test;
  import txq_pkg::*;
  localparam logic [3:0] A_CMD = `TXQ_OFS_MMU_CMD, A_PN = `TXQ_OFS_PKT_NUM;
  localparam logic [3:0] A_TCR = `TXQ_OFS_TX_CTRL, A_ST = `TXQ_OFS_INT_STAT;
  localparam logic [7:0] C_ENQ = {`TXQ_CMD_ENQUEUE, 5'h00};
  logic       mclk, rst, reg_wr, reg_rd, defer_ok, irq, fail_next;
  logic       mac_start, mac_done, mac_fail;
  logic [3:0] reg_addr, delay;
  logic [7:0] reg_wdata, reg_rdata, n_sent;
  txq_pn_t    mac_pn, last_pn, pa, pb, pc, pd;
  int         num_errors = 0;
  int         n_tests = 0;
  always #5 mclk = ~mclk;
  txq_top txq_top_inst (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .buf_wr(), .buf_ptr(),
    .buf_wdata(), .defer_ok(defer_ok), .link_layer_status(8'h5C), .mac_start(mac_start),
    .mac_pn(mac_pn), .mac_done(mac_done), .mac_fail(mac_fail), .irq(irq));
  txq_mac_model txq_mac_model_inst (.mclk(mclk), .rst(rst), .mac_start(mac_start),
    .mac_pn(mac_pn), .mac_done(mac_done), .mac_fail(mac_fail), .delay(delay),
    .fail_next(fail_next), .n_sent(n_sent), .last_pn(last_pn));
  task automatic end_sim();
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic chk_rd(input string nm, input logic [3:0] a, input logic [7:0] m,
                        input logic [7:0] ex, output logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
    `CHK(nm, ex, d & m)
  endtask
  // Waits until the model has answered t sends
  task automatic wait_sent(input logic [7:0] t);
    for (int i = 0; i < 300 && n_sent !== t; i++) @(posedge mclk);
    `CHK("sent", t, n_sent)
    if (n_sent !== t) begin
      end_sim();
    end
    repeat (2) @(posedge mclk);
  endtask
  task automatic alloc(input logic [4:0] pg, input logic ei, input logic ef, output txq_pn_t pn);
    logic [7:0] d;
    wr(A_CMD, {`TXQ_CMD_ALLOC, pg});
    chk_rd("alloc_fail", `TXQ_OFS_ALLOC_RES, 8'h80, {ef, 7'h00}, d);
    pn = d[2:0];
    `CHK("irq_alloc", ei, irq)
    chk_rd("alloc_flag", A_ST, 8'h02, ef ? 8'h00 : 8'h02, d);
    wr(A_ST, 8'h02);
  endtask
  task automatic load_enq(input txq_pn_t pn);
    wr(A_PN, {5'h00, pn});
    wr(`TXQ_OFS_PTR, 8'h3C);
    wr(`TXQ_OFS_DATA, 8'hA5);
    wr(`TXQ_OFS_DATA, 8'h5A);
    wr(A_CMD, C_ENQ);
  endtask
  task automatic t_reset();
    logic [7:0] d;
    chk_rd("ctrl", `TXQ_OFS_CTRL, 8'hFF, `TXQ_RST_CTRL, d);
    chk_rd("tcr", A_TCR, 8'hFF, `TXQ_RST_TCR, d);
    chk_rd("mask", `TXQ_OFS_INT_MASK, 8'hFF, `TXQ_RST_MASK, d);
    chk_rd("drained", A_ST, 8'h07, 8'h04, d);
    chk_rd("unmapped", 4'hF, 8'hFF, 8'h00, d);
    `CHK("irq_rst", 1'b0, irq)
  endtask
  task automatic t_alloc();
    txq_pn_t big;
    alloc(5'h00, 1'b0, 1'b0, pa);
    wr(`TXQ_OFS_INT_MASK, 8'h02);
    alloc(5'h00, 1'b1, 1'b0, pb);
    `CHK("pn_unique", 1'b1, pa != pb)
    alloc(5'h10, 1'b0, 1'b1, big);
    `CHK("irq_clear", 1'b0, irq)
    wr(`TXQ_OFS_INT_MASK, 8'h00);
  endtask
  // Full duplex ignores the deferral input, held low here
  task automatic t_send();
    txq_pn_t big;
    logic [7:0] d;
    wr(A_TCR, 8'h01);
    load_enq(pa);
    for (int i = 0; i < 50 && mac_start !== 1'b1; i++) @(posedge mclk);
    #1;
    `CHK("started", 1'b1, mac_start)
    `CHK("mac_pn", pa, mac_pn)
    wait_sent(8'h01);
    chk_rd("no_compl", A_ST, 8'h05, 8'h04, d);
    chk_rd("q_empty", `TXQ_OFS_FIFO_PORTS, 8'h80, 8'h80, d);
    wr(`TXQ_OFS_INT_MASK, 8'h04);
    `CHK("irq_drained", 1'b1, irq)
    chk_rd("isr_stat", A_ST, 8'h07, 8'h04, d);
    wr(`TXQ_OFS_INT_MASK, 8'h00);
    // Fifteen pages fit only if the sent packet was freed
    alloc(5'h0E, 1'b0, 1'b0, big);
    wr(A_PN, {5'h00, big});
    wr(A_CMD, {`TXQ_CMD_RELEASE, 5'h00});
  endtask
  task automatic t_gate();
    logic [7:0] d;
    wr(A_TCR, 8'h00);
    delay <= 4'h0;
    load_enq(pb);
    repeat (8) @(posedge mclk);
    `CHK("held_off", 1'b0, mac_start)
    chk_rd("not_drained", A_ST, 8'h04, 8'h00, d);
    wr(`TXQ_OFS_CTRL, 8'h03);
    wr(A_TCR, 8'h01);
    repeat (8) @(posedge mclk);
    `CHK("deferred", 1'b0, mac_start)
    defer_ok <= 1'b1;
    wait_sent(8'h02);
    `CHK("pn_half", pb, last_pn)
    wr(`TXQ_OFS_CTRL, 8'h01);
  endtask
  task automatic t_fail();
    logic [7:0] d;
    alloc(5'h00, 1'b0, 1'b0, pc);
    alloc(5'h00, 1'b0, 1'b0, pd);
    wr(A_TCR, 8'h00);
    load_enq(pc);
    load_enq(pd);
    fail_next <= 1'b1;
    wr(A_TCR, 8'h01);
    wait_sent(8'h03);
    fail_next <= 1'b0;
    chk_rd("ten_clr", A_TCR, 8'h01, 8'h00, d);
    chk_rd("tx_flag", A_ST, 8'h05, 8'h01, d);
    chk_rd("fail_pn", `TXQ_OFS_FIFO_PORTS, 8'h87, {5'h00, pc}, d);
    `CHK("halted", 1'b0, mac_start)
    chk_rd("link", `TXQ_OFS_LINK_STAT, 8'hFF, 8'h5C, d);
    wr(A_PN, {5'h00, pc});
    wr(A_TCR, 8'h01);
    wr(A_CMD, C_ENQ);
    wait_sent(8'h05);
    `CHK("retry_pn", pc, last_pn)
    chk_rd("flag_held", A_ST, 8'h01, 8'h01, d);
    wr(A_ST, 8'h01);
    chk_rd("flag_pop", A_ST, 8'h05, 8'h04, d);
    // Second failure: the packet is freed instead of retried
    alloc(5'h00, 1'b0, 1'b0, pc);
    fail_next <= 1'b1;
    load_enq(pc);
    wait_sent(8'h06);
    fail_next <= 1'b0;
    wr(A_ST, 8'h01);
    wr(A_CMD, {`TXQ_CMD_RELEASE, 5'h00});
    // All sixteen pages fit only if the failed packet was freed
    alloc(5'h0F, 1'b0, 1'b0, pc);
  endtask
  initial begin
    mclk      = 1'b0;
    rst       = 1'b1;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 4'h0;
    reg_wdata = 8'h00;
    defer_ok  = 1'b0;
    delay     = 4'h3;
    fail_next = 1'b0;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    t_reset();
    t_alloc();
    t_send();
    t_gate();
    t_fail();
    end_sim();
  end
endmodule
`default_nettype wire
